// [fan_zone_consts.svh]
// register offsets, reset values, field positions and timing figures of the fan zone bank
// assumes it is included by bare name wherever a constant is needed
`ifndef FAN_ZONE_CONSTS_SVH
`define FAN_ZONE_CONSTS_SVH

`define OFS_BOOST_HYST_12    8'hc0
`define OFS_BOOST_HYST_34    8'hc1
`define OFS_SPIKE_SMOOTH_12  8'hc2
`define OFS_MIN_DUTY_HYST_12 8'hc3

`define RST_BOOST_HYST_12    8'h44
`define RST_BOOST_HYST_34    8'h44
`define RST_SPIKE_SMOOTH_12  8'h00
`define RST_MIN_DUTY_HYST_12 8'h00

// nibble fields
`define LO_NIB_MSB 3
`define LO_NIB_LSB 0
`define HI_NIB_MSB 7
`define HI_NIB_LSB 4
// smoothing control fields
`define Z1_PERIOD_MSB 2
`define Z1_PERIOD_LSB 0
`define Z1_ENABLE_BIT 3
`define Z2_PERIOD_MSB 6
`define Z2_PERIOD_LSB 4
`define Z2_ENABLE_BIT 7

`define FULL_DUTY 8'hff
`define READ_IDLE 8'h00

// smoothing windows in milliseconds, code 0 to 7
`define SMOOTH_MS_0 64'd11800
`define SMOOTH_MS_1 64'd7000
`define SMOOTH_MS_2 64'd4400
`define SMOOTH_MS_3 64'd3000
`define SMOOTH_MS_4 64'd1600
`define SMOOTH_MS_5 64'd800
`define SMOOTH_MS_6 64'd600
`define SMOOTH_MS_7 64'd400

// filter: weight of a new sample is 1/2^shift, so one window spans 2^shift updates
`define FILTER_SHIFT 4
`define FILTER_STEPS 64'd16
`define CLK_KHZ_DEFAULT 200000

`endif

// [fan_zone_pkg.sv]
// types shared by the fan zone bank and its temperature smoother
// assumes nothing of its surroundings
package fan_zone_pkg;

  typedef enum logic {
    BOOST_IDLE = 1'b0,
    BOOST_HELD = 1'b1
  } boost_state_type;

  typedef struct packed {
    logic [7:0]                 boost_hyst_12;
    logic [7:0]                 boost_hyst_34;
    logic [7:0]                 spike_smooth_12;
    logic [7:0]                 min_duty_hyst_12;
    boost_state_type [3:0]      boost;
    logic [3:0][7:0]            duty;
    logic [3:0]                 limit_over;
    logic [1:0][7:0]            filtered;
    logic [7:0]                 rdata;
  } bank_state_type;

  typedef struct packed {
    logic [1:0][31:0] interval_cnt;
    logic [1:0][11:0] acc;
  } smooth_state_type;

endpackage

// [smooth_if.sv]
// carries raw temperatures and smoothing periods to the smoother and filtered values back
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface smooth_if;
  logic [1:0][7:0] raw_temp;
  logic [1:0][2:0] period;
  logic [1:0][7:0] filtered;

  modport bank   (output raw_temp, output period, input filtered);
  modport filter (input raw_temp, input period, output filtered);
endinterface
`default_nettype wire

// [temp_smoother.sv]
// spike smoothing filter for zones 1 and 2: first-order average updated at a
// rate chosen by the period code; runs whether or not smoothing is enabled
// assumes raw temperatures are synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "fan_zone_consts.svh"
module temp_smoother #(
  parameter int CLK_KHZ = `CLK_KHZ_DEFAULT
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // filter side of the carrier
  smooth_if.filter  smooth
);

  generate
    if (CLK_KHZ < 1) begin : g_bad_clk
      $error("temp_smoother: CLK_KHZ must be positive");
    end
  endgenerate

  fan_zone_pkg::smooth_state_type s_q;
  fan_zone_pkg::smooth_state_type s_d;

  // cycles between filter updates for a period code
  function automatic logic [31:0] update_cycles(input logic [2:0] code);
    logic [63:0] ms;
    logic [63:0] cyc;
    case (code)
      3'h0:    ms = `SMOOTH_MS_0;
      3'h1:    ms = `SMOOTH_MS_1;
      3'h2:    ms = `SMOOTH_MS_2;
      3'h3:    ms = `SMOOTH_MS_3;
      3'h4:    ms = `SMOOTH_MS_4;
      3'h5:    ms = `SMOOTH_MS_5;
      3'h6:    ms = `SMOOTH_MS_6;
      default: ms = `SMOOTH_MS_7;
    endcase
    cyc = (ms * 64'(CLK_KHZ)) / `FILTER_STEPS;
    if (cyc == 64'h0) begin
      cyc = 64'h1;
    end
    return cyc[31:0];
  endfunction

  always_comb begin
    s_d = s_q;
    for (int z = 0; z < 2; z++) begin
      // period change only moves the next update point; accumulator kept
      if (s_q.interval_cnt[z] + 32'h1 >= update_cycles(smooth.period[z])) begin
        s_d.interval_cnt[z] = 32'h0;
        s_d.acc[z] = s_q.acc[z] - (s_q.acc[z] >> `FILTER_SHIFT)
                     + {4'h0, smooth.raw_temp[z]};
      end else begin
        s_d.interval_cnt[z] = s_q.interval_cnt[z] + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int z = 0; z < 2; z++) begin
      smooth.filtered[z] = s_q.acc[z][11:4];
    end
  end

endmodule
`default_nettype wire

// [fan_zone_boost_smoothing_regs.sv]
// fan boost hysteresis registers for four zones, spike smoothing and minimum duty registers for zones 1 and 2,
// with the per-zone boost hold, temperature selection and duty request
// assumes the serial management slave presents decoded byte accesses on the
// reg_* port and that all inputs are synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "fan_zone_consts.svh"
module fan_zone_boost_smoothing_regs #(
  parameter int CLK_KHZ = `CLK_KHZ_DEFAULT
) (
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rstn_i,
  // register access from the management interface
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic            reg_wr_i,
  input  wire logic [7:0]      reg_wdata_i,
  input  wire logic            reg_rd_i,
  output logic [7:0]           reg_rdata_o,
  // zone temperatures, thresholds and table duties
  input  wire logic [3:0][7:0] temp_zone_i,
  input  wire logic [3:0][7:0] boost_temp_i,
  input  wire logic [1:0][7:0] base_temp_i,
  input  wire logic [3:0][7:0] limit_high_i,
  input  wire logic [3:0][7:0] table_duty_i,
  // results
  output logic [3:0][7:0]      duty_zone_o,
  output logic [3:0]           limit_over_o,
  output logic [1:0][7:0]      filtered_temp_o,
  output logic [3:0]           table_step_hysteresis_o,
  output logic [3:0]           minimum_duty_select_o
);

  generate
    if (CLK_KHZ < 1) begin : g_bad_clk
      $error("fan_zone_boost_smoothing_regs: CLK_KHZ must be positive");
    end
  endgenerate

  fan_zone_pkg::bank_state_type s_q;
  fan_zone_pkg::bank_state_type s_d;

  smooth_if smooth ();

  temp_smoother #(
    .CLK_KHZ (CLK_KHZ)
  ) u_smoother (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .smooth     (smooth.filter)
  );

  // boost hysteresis in whole degrees, unsigned 0 to 15
  function automatic logic [3:0] boost_hyst(input fan_zone_pkg::bank_state_type s,
                                            input int z);
    case (z)
      0:       return s.boost_hyst_12[`LO_NIB_MSB:`LO_NIB_LSB];
      1:       return s.boost_hyst_12[`HI_NIB_MSB:`HI_NIB_LSB];
      2:       return s.boost_hyst_34[`LO_NIB_MSB:`LO_NIB_LSB];
      default: return s.boost_hyst_34[`HI_NIB_MSB:`HI_NIB_LSB];
    endcase
  endfunction

  // sixteen duty codes spread evenly over the full duty range
  function automatic logic [7:0] duty_from_code(input logic [3:0] code);
    return {code, code};
  endfunction

  // applies one byte write to the register copy; unmapped addresses change nothing
  function automatic fan_zone_pkg::bank_state_type reg_write(
    input fan_zone_pkg::bank_state_type s,
    input logic [7:0]                   addr,
    input logic [7:0]                   data
  );
    fan_zone_pkg::bank_state_type r;
    r = s;
    case (addr)
      `OFS_BOOST_HYST_12:    r.boost_hyst_12    = data;
      `OFS_BOOST_HYST_34:    r.boost_hyst_34    = data;
      `OFS_SPIKE_SMOOTH_12:  r.spike_smooth_12  = data;
      `OFS_MIN_DUTY_HYST_12: r.min_duty_hyst_12 = data;
      default:               r = s;
    endcase
    return r;
  endfunction

  // value a read returns for a byte address; unmapped addresses read as zero
  function automatic logic [7:0] reg_read(
    input fan_zone_pkg::bank_state_type s,
    input logic [7:0]                   addr
  );
    case (addr)
      `OFS_BOOST_HYST_12:    return s.boost_hyst_12;
      `OFS_BOOST_HYST_34:    return s.boost_hyst_34;
      `OFS_SPIKE_SMOOTH_12:  return s.spike_smooth_12;
      `OFS_MIN_DUTY_HYST_12: return s.min_duty_hyst_12;
      default:               return `READ_IDLE;
    endcase
  endfunction

  // a held boost lets go only once the temperature is more than the hysteresis
  // below the boost point; the sum is widened so a hot reading cannot wrap
  function automatic logic boost_release(
    input logic [7:0] temp,
    input logic [7:0] boost,
    input logic [3:0] hyst
  );
    logic [8:0] sum;
    sum = {1'b0, temp} + {5'h00, hyst};
    return sum < {1'b0, boost};
  endfunction

  // duty request: boost outranks the minimum duty, which outranks the table
  function automatic logic [7:0] zone_duty(
    input logic       held,
    input logic       below_base,
    input logic [3:0] min_code,
    input logic [7:0] table_duty
  );
    if (held) begin
      return `FULL_DUTY;
    end
    if (below_base) begin
      return duty_from_code(min_code);
    end
    return table_duty;
  endfunction

  logic [1:0]      smooth_en;
  logic [3:0][7:0] eff_temp;

  always_comb begin
    smooth_en[0] = s_q.spike_smooth_12[`Z1_ENABLE_BIT];
    smooth_en[1] = s_q.spike_smooth_12[`Z2_ENABLE_BIT];
    smooth.period[0] = s_q.spike_smooth_12[`Z1_PERIOD_MSB:`Z1_PERIOD_LSB];
    smooth.period[1] = s_q.spike_smooth_12[`Z2_PERIOD_MSB:`Z2_PERIOD_LSB];
    // raw readings go to the filter untouched and are never replaced
    smooth.raw_temp[0] = temp_zone_i[0];
    smooth.raw_temp[1] = temp_zone_i[1];
    eff_temp = temp_zone_i;
    for (int z = 0; z < 2; z++) begin
      if (smooth_en[z]) begin
        eff_temp[z] = smooth.filtered[z];
      end
    end
  end

  always_comb begin
    s_d = s_q;
    // register writes; unmapped addresses change nothing
    if (reg_wr_i) begin
      s_d = reg_write(s_q, reg_addr_i, reg_wdata_i);
    end
    // register reads, answered one cycle later; a read beside a write sees the old value
    if (reg_rd_i) begin
      s_d.rdata = reg_read(s_q, reg_addr_i);
    end
    // per-zone boost hold and duty request
    for (int z = 0; z < 4; z++) begin
      case (s_q.boost[z])
        fan_zone_pkg::BOOST_IDLE: begin
          if (eff_temp[z] > boost_temp_i[z]) begin
            s_d.boost[z] = fan_zone_pkg::BOOST_HELD;
          end
        end
        fan_zone_pkg::BOOST_HELD: begin
          if (boost_release(eff_temp[z], boost_temp_i[z], boost_hyst(s_q, z))) begin
            s_d.boost[z] = fan_zone_pkg::BOOST_IDLE;
          end
        end
        default: s_d.boost[z] = fan_zone_pkg::BOOST_IDLE;
      endcase
      // zones 3 and 4 have no minimum duty field here, so only the first two drop to it
      s_d.duty[z] = zone_duty(s_d.boost[z] == fan_zone_pkg::BOOST_HELD,
                              z < 2 && eff_temp[z] < base_temp_i[z[0]],
                              s_q.min_duty_hyst_12[`HI_NIB_MSB:`HI_NIB_LSB],
                              table_duty_i[z]);
      s_d.limit_over[z] = eff_temp[z] > limit_high_i[z];
    end
    s_d.filtered[0] = smooth.filtered[0];
    s_d.filtered[1] = smooth.filtered[1];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_q.boost_hyst_12    <= `RST_BOOST_HYST_12;
      s_q.boost_hyst_34    <= `RST_BOOST_HYST_34;
      s_q.spike_smooth_12  <= `RST_SPIKE_SMOOTH_12;
      s_q.min_duty_hyst_12 <= `RST_MIN_DUTY_HYST_12;
      s_q.boost            <= '{default: fan_zone_pkg::BOOST_IDLE};
      s_q.duty             <= '0;
      s_q.limit_over       <= '0;
      s_q.filtered         <= '0;
      s_q.rdata            <= `READ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // table hysteresis is held here for the lookup logic; nonzero is software's duty
  always_comb begin
    reg_rdata_o             = s_q.rdata;
    duty_zone_o             = s_q.duty;
    limit_over_o            = s_q.limit_over;
    filtered_temp_o         = s_q.filtered;
    table_step_hysteresis_o = s_q.min_duty_hyst_12[`LO_NIB_MSB:`LO_NIB_LSB];
    minimum_duty_select_o   = s_q.min_duty_hyst_12[`HI_NIB_MSB:`HI_NIB_LSB];
  end

endmodule
`default_nettype wire

// [fan_zone_checker.sv]
// port checker for the fan zone register bank
// assumes it is bound to the bank's top module and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module fan_zone_checker (
  // clock and reset
  input wire logic            core_clk_i,
  input wire logic            rstn_i,
  // register port
  input wire logic [7:0]      reg_addr_i,
  input wire logic            reg_wr_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic            reg_rd_i,
  input wire logic [7:0]      reg_rdata_o,
  // fan evaluation
  input wire logic [3:0][7:0] temp_zone_i,
  input wire logic [3:0][7:0] boost_temp_i,
  input wire logic [3:0][7:0] limit_high_i,
  input wire logic [3:0][7:0] duty_zone_o,
  input wire logic [3:0]      limit_over_o,
  input wire logic [3:0]      table_step_hysteresis_o,
  input wire logic [3:0]      minimum_duty_select_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_boost_zone_three: assert property (
    temp_zone_i[2] > boost_temp_i[2] |=> duty_zone_o[2] == 8'hff)
    else $error("zone 3 not at full duty above boost");
  a_boost_zone_four: assert property (
    temp_zone_i[3] > boost_temp_i[3] |=> duty_zone_o[3] == 8'hff)
    else $error("zone 4 not at full duty above boost");
  a_limit_set_three: assert property (
    temp_zone_i[2] > limit_high_i[2] |=> limit_over_o[2])
    else $error("zone 3 limit flag missing");
  a_limit_clear_three: assert property (
    temp_zone_i[2] <= limit_high_i[2] |=> !limit_over_o[2])
    else $error("zone 3 limit flag spurious");
  a_duty_fields_write: assert property (
    reg_wr_i && reg_addr_i == 8'hc3 |=>
      {minimum_duty_select_o, table_step_hysteresis_o} == $past(reg_wdata_i))
    else $error("duty fields do not follow write");
  a_duty_fields_read: assert property (
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'hc3 |=>
      reg_rdata_o == {minimum_duty_select_o, table_step_hysteresis_o})
    else $error("duty register read wrong");
  a_rdata_holds: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_read: assert property (
    reg_rd_i && (reg_addr_i < 8'hc0 || reg_addr_i > 8'hc3) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind fan_zone_boost_smoothing_regs fan_zone_checker fan_zone_checker_inst (.core_clk_i,
  .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .temp_zone_i,
  .boost_temp_i, .limit_high_i, .duty_zone_o, .limit_over_o, .table_step_hysteresis_o,
  .minimum_duty_select_o);
`default_nettype wire

// [fan_zone_boost_smoothing_regs_bench.sv]
// self-checking bench for the fan zone register bank
// assumes the bank's files and its checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module fan_zone_boost_smoothing_regs_bench;
  logic            core_clk_i = 1'b0;
  logic            rstn_i = 1'b0;
  logic [7:0]      reg_addr_i = 8'h00;
  logic            reg_wr_i = 1'b0;
  logic [7:0]      reg_wdata_i = 8'h00;
  logic            reg_rd_i = 1'b0;
  logic [7:0]      reg_rdata_o;
  logic [3:0][7:0] temp_zone_i = '0;
  logic [3:0][7:0] boost_temp_i = {4{8'd200}};
  logic [1:0][7:0] base_temp_i = '0;
  logic [3:0][7:0] limit_high_i = {8'd200, 8'd45, 8'd200, 8'd200};
  logic [3:0][7:0] table_duty_i = {4{8'h20}};
  logic [3:0][7:0] duty_zone_o;
  logic [3:0]      limit_over_o;
  logic [1:0][7:0] filtered_temp_o;
  logic [3:0]      table_step_hysteresis_o;
  logic [3:0]      minimum_duty_select_o;
  logic [3:0][7:0] hy = {8'd7, 8'd10, 8'd0, 8'd15};
  int              n_fail = 0;
  int              samples_checked = 0;

  fan_zone_boost_smoothing_regs #(.CLK_KHZ(1)) fan_zone_boost_smoothing_regs_inst (
    .core_clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .temp_zone_i, .boost_temp_i, .base_temp_i, .limit_high_i, .table_duty_i, .duty_zone_o,
    .limit_over_o, .filtered_temp_o, .table_step_hysteresis_o, .minimum_duty_select_o);

  always #2.5 core_clk_i = ~core_clk_i;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask

  task settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // cycles between two filter updates on zone 1; one window spans 16 updates at 1 kHz
  task period_check(input logic [2:0] code, input int window_ms);
    int         n;
    logic [7:0] last;
    wr(8'hc2, {5'h00, code});
    #1;
    for (int k = 0; k < 2; k++) begin
      last = filtered_temp_o[0];
      n    = 0;
      while (filtered_temp_o[0] === last && n < 1000) begin
        @(posedge core_clk_i);
        #1;
        n++;
      end
    end
    samples_checked++;
    if (n != window_ms / 16) begin
      n_fail++;
      $display("mismatch at %0t: code %0d updated after %0d cycles", $time, code, n);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    close_out;
  end

  initial begin
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(8'hc0, 8'h44);
    rd(8'hc1, 8'h44);
    rd(8'hc2, 8'h00);
    rd(8'hc3, 8'h00);
    wr(8'hc4, 8'h5a);
    rd(8'hc4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'hc0 + i[7:0], 8'ha5 ^ i[7:0]);
      rd(8'hc0 + i[7:0], 8'ha5 ^ i[7:0]);
    end
    wr(8'hc0, 8'h0f);
    wr(8'hc1, 8'h7a);
    wr(8'hc2, 8'h00);
    $display("test registers done");
    // boost entry, hold at the hysteresis edge, release one degree lower
    @(posedge core_clk_i);
    boost_temp_i <= {4{8'd50}};
    temp_zone_i  <= {4{8'd51}};
    settle;
    for (int z = 0; z < 4; z++) chk(duty_zone_o[z], 8'hff);
    @(posedge core_clk_i);
    for (int z = 0; z < 4; z++) temp_zone_i[z] <= 8'd50 - hy[z];
    settle;
    for (int z = 0; z < 4; z++) chk(duty_zone_o[z], 8'hff);
    @(posedge core_clk_i);
    for (int z = 0; z < 4; z++) temp_zone_i[z] <= 8'd49 - hy[z];
    settle;
    for (int z = 0; z < 4; z++) chk(duty_zone_o[z], 8'h20);
    $display("test boost done");
    @(posedge core_clk_i);
    base_temp_i <= {2{8'd100}};
    temp_zone_i <= {4{8'd40}};
    for (int c = 0; c < 16; c++) begin
      wr(8'hc3, {c[3:0], 4'h1});
      settle;
      chk(duty_zone_o[0], {2{c[3:0]}});
      chk(duty_zone_o[1], {2{c[3:0]}});
      chk(duty_zone_o[2], 8'h20);
      chk({minimum_duty_select_o, table_step_hysteresis_o}, {c[3:0], 4'h1});
    end
    $display("test minimum duty done");
    @(posedge core_clk_i);
    base_temp_i     <= '0;
    limit_high_i[0] <= 8'd60;
    temp_zone_i[0]  <= 8'd80;
    wr(8'hc2, 8'h77);
    repeat (4000) @(posedge core_clk_i);
    #1;
    chk(filtered_temp_o[0], 8'd80);
    chk({7'h0, limit_over_o[0]}, 8'h01);
    @(posedge core_clk_i);
    temp_zone_i[0] <= 8'd20;
    wr(8'hc2, 8'h7f);
    settle;
    chk({7'h0, limit_over_o[0]}, 8'h01);
    chk({7'h0, filtered_temp_o[0] >= 8'd76}, 8'h01);
    wr(8'hc2, 8'h77);
    settle;
    chk({7'h0, limit_over_o[0]}, 8'h00);
    $display("test smoothing done");
    // a hot raw reading keeps every update moving the filtered value
    @(posedge core_clk_i);
    temp_zone_i[0] <= 8'hff;
    period_check(3'h7, 400);
    period_check(3'h6, 600);
    period_check(3'h5, 800);
    period_check(3'h4, 1600);
    period_check(3'h3, 3000);
    period_check(3'h2, 4400);
    period_check(3'h1, 7000);
    period_check(3'h0, 11800);
    $display("test smoothing periods done");
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(8'hc0, 8'h44);
    rd(8'hc3, 8'h00);
    $display("test reset done");
    close_out;
  end
endmodule
`default_nettype wire
